// [l2ce_regs.svh]
// Register map, field positions and codes of the cache error reporter.
// Included by the reporter; assumes 12-bit AXI4-Lite byte addresses.
`ifndef L2CE_REGS_SVH
`define L2CE_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFF_CTRL 12'h000
`define OFF_CLASS 12'h004
`define OFF_TRAPEN 12'h008
`define OFF_SEL 12'h00c
`define OFF_DESR_LO 12'h010
`define OFF_DESR_HI 12'h014
`define OFF_ESR 12'h018
`define OFF_ADDR_LO 12'h01c
`define OFF_ADDR_HI 12'h020

// ****************************************
// Fields and reset values
// ****************************************
`define CTRL_REPORT 0
`define CTRL_ARRAY 1
`define CTRL_STEER_LO 4
`define CTRL_RST 32'h0000_0003
`define CLASS_TW 0
`define CLASS_IF 1
`define CLASS_LD 2
`define CLASS_SOC 3
`define TRAPEN_SW 0
`define TRAPEN_HW 1
`define DESR_F 31
`define DESR_TYPE_LO 24
`define DESR_PEND_SW 0
`define DESR_PEND_HW 1
`define ESR_ACC 31
`define ESR_RW 30
`define ESR_MODE 29
`define ESR_STRAND_LO 16
`define AXI_OKAY 2'h0
`define AXI_DECERR 2'h3

// ****************************************
// Packet error codes and error types
// ****************************************
`define ERR_NONE 2'h0
`define ERR_CE 2'h1
`define ERR_UE 2'h2
`define ERR_ND 2'h3
`define ET_ITLB 5'h01
`define ET_IFETCH 5'h02
`define ET_DTLB 5'h03
`define ET_LOAD 5'h04
`define ET_HWCE 5'h09
`define ET_UE 5'h10
`define ET_ND 5'h11
`define ET_SWCE 5'h14
`define FULL_STORE 4'hf

`endif

// [l2ce_pkg.sv]
// Types shared by the cache error reporter.
// Request kinds as tagged by the cache pipeline.
package l2ce_pkg;
    typedef enum logic [2:0] {
        REQ_ITLB = 3'h0,
        REQ_DTLB = 3'h1,
        REQ_IFETCH = 3'h2,
        REQ_LOAD = 3'h3,
        REQ_PREFETCH = 3'h4,
        REQ_STORE = 3'h5,
        REQ_DMA_RD = 3'h6,
        REQ_WRITEBACK = 3'h7
    } req_t;
    typedef logic [1:0] err_t;
endpackage : l2ce_pkg

// [l2_correctable_error_report.sv]
// Cache-side error checking, packet reporting and per-strand trap state.
// Assumes the cache pipeline, cores and AXI4-Lite master share CLK_SYS.
//
// What this block does
// - Data sublines checked by SECDED, tag by SEC
// - Store below 32 subline bits is partial
// - Sync errors in load-return, async in indication
// - Two-bit code: 01 CE, 10 UE, 11 not-data
// - Indications go to requester or steered strand
// - UE or not-data on load: precise trap
// - CE on load: disrupting software-recoverable trap
// - Indication UE, DMA/prefetch CE: software-recoverable
// - Other indication CE: hardware-fixed trap
// - With arrays disabled only not-data is reported
// - Report enable gates CE sending; capture always
// - Class enable gates status record and trap
// - Software trap enable presents load trap
// - Hardware trap enable presents store trap
// - Trap stays pending while enable clear
// - Taken only if interrupts on or unprivileged
// - Clearing first-error flag discards pending trap
// - Instruction walk CE: full status, address
// - Data walk CE: flag, strand, syndrome, address
// - Walk CE writes walk type if enabled
// - Fetch and load CE write their types
// - Corrected data returned, stored line untouched
// - Type codes 1..4 at status bits 60:56
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "l2ce_regs.svh"

module l2_correctable_error_report
    import l2ce_pkg::*;
#(
    parameter int NUM_STRANDS = 8,
    parameter int STRAND_W = 3
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic [11:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [11:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic ACC_VALID,
    input wire logic [2:0] ACC_REQ,
    input wire logic [STRAND_W-1:0] ACC_STRAND,
    input wire logic ACC_RW,
    input wire logic ACC_MODE,
    input wire logic [39:6] ACC_PA,
    input wire logic [31:0] ACC_DATA,
    input wire logic [6:0] ACC_CHECK,
    input wire logic [3:0] ACC_BYTE_EN,
    input wire logic ACC_TAG_CE,
    input wire logic ACC_NOT_DATA,
    input wire logic [NUM_STRANDS-1:0] INTERRUPT_ENABLE,
    input wire logic [NUM_STRANDS-1:0] HYPERPRIVILEGE,
    output logic LR_VALID,
    output logic [1:0] LR_ERR,
    output logic [STRAND_W-1:0] LR_STRAND,
    output logic [31:0] LR_DATA,
    output logic EI_VALID,
    output logic [1:0] EI_ERR,
    output logic [STRAND_W-1:0] EI_STRAND,
    output logic PRECISE_TRAP,
    output logic [STRAND_W-1:0] PRECISE_STRAND,
    output logic [NUM_STRANDS-1:0] SW_TRAP,
    output logic [NUM_STRANDS-1:0] HW_TRAP
);

    // ****************************************
    // Check code
    // ****************************************
    // Data bit j sits at the j-th Hamming position that is not a power of two
    function automatic logic [5:0] pos_of(input int j);
        logic [5:0] p;
        int n;
        p = 6'h2;
        n = -1;
        for (int k = 0; k < 64; k++) begin
            if (n < j) begin
                p = p + 6'h1;
                if ((p & (p - 6'h1)) != 6'h0) begin
                    n = n + 1;
                end
            end
        end
        return p;
    endfunction : pos_of

    function automatic logic [5:0] hamming(input logic [31:0] d);
        logic [5:0] c;
        c = 6'h0;
        for (int j = 0; j < 32; j++) begin
            if (d[j]) begin
                c = c ^ pos_of(j);
            end
        end
        return c;
    endfunction : hamming

    function automatic logic [31:0] flip_of(input logic [5:0] s);
        logic [31:0] m;
        m = 32'h0;
        for (int j = 0; j < 32; j++) begin
            m[j] = (pos_of(j) == s);
        end
        return m;
    endfunction : flip_of

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // ****************************************
    // Software registers
    // ****************************************
    logic [31:0] ctrl_r;
    logic [3:0] class_r;
    logic [1:0] trapen_r;
    logic [STRAND_W-1:0] sel_r;
    logic [31:0] esr_r;
    logic [39:6] addr_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_write;
    logic wr_hit;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [NUM_STRANDS-1:0] f_v;
    logic [NUM_STRANDS-1:0] psw_v;
    logic [NUM_STRANDS-1:0] phw_v;
    logic [4:0] et_v [NUM_STRANDS];

    wire report = ctrl_r[`CTRL_REPORT];
    wire array_en = ctrl_r[`CTRL_ARRAY];
    wire [STRAND_W-1:0] steer = ctrl_r[`CTRL_STEER_LO +: STRAND_W];

    assign do_write = !AWREADY && !WREADY && !BVALID;

    always_comb begin
        wr_hit = 1'b1;
        unique case (awaddr_r)
            `OFF_CTRL, `OFF_CLASS, `OFF_TRAPEN, `OFF_SEL, `OFF_DESR_HI: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Write channels are taken in either order, then answered together
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
            BVALID <= 1'b0;
            BRESP <= `AXI_OKAY;
            awaddr_r <= 12'h0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
        end else begin
            if (AWVALID && AWREADY) begin
                AWREADY <= 1'b0;
                awaddr_r <= AWADDR;
            end
            if (WVALID && WREADY) begin
                WREADY <= 1'b0;
                wdata_r <= WDATA;
                wstrb_r <= WSTRB;
            end
            if (do_write) begin
                BVALID <= 1'b1;
                BRESP <= wr_hit ? `AXI_OKAY : `AXI_DECERR;
            end
            if (BVALID && BREADY) begin
                BVALID <= 1'b0;
                AWREADY <= 1'b1;
                WREADY <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_r <= `CTRL_RST;
            class_r <= 4'h0;
            trapen_r <= 2'h0;
            sel_r <= '0;
        end else if (do_write) begin
            unique case (awaddr_r)
                `OFF_CTRL: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
                `OFF_CLASS: class_r <= wdata_r[3:0] & {4{wstrb_r[0]}} | class_r & ~{4{wstrb_r[0]}};
                `OFF_TRAPEN: trapen_r <= wstrb_r[0] ? wdata_r[1:0] : trapen_r;
                `OFF_SEL: sel_r <= wstrb_r[0] ? wdata_r[STRAND_W-1:0] : sel_r;
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_word = 32'h0;
        unique case (ARADDR)
            `OFF_CTRL: rd_word = ctrl_r;
            `OFF_CLASS: rd_word = {28'h0, class_r};
            `OFF_TRAPEN: rd_word = {30'h0, trapen_r};
            `OFF_SEL: rd_word = {{(32-STRAND_W){1'b0}}, sel_r};
            `OFF_DESR_LO: begin
                rd_word[`DESR_PEND_SW] = psw_v[sel_r];
                rd_word[`DESR_PEND_HW] = phw_v[sel_r];
            end
            `OFF_DESR_HI: begin
                rd_word[`DESR_F] = f_v[sel_r];
                rd_word[`DESR_TYPE_LO +: 5] = et_v[sel_r];
            end
            `OFF_ESR: rd_word = esr_r;
            `OFF_ADDR_LO: rd_word = addr_r[37:6];
            `OFF_ADDR_HI: rd_word = {30'h0, addr_r[39:38]};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            ARREADY <= 1'b1;
            RVALID <= 1'b0;
            RDATA <= 32'h0;
            RRESP <= `AXI_OKAY;
        end else if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RDATA <= rd_word;
            RRESP <= rd_hit ? `AXI_OKAY : `AXI_DECERR;
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
        end
    end

    // ****************************************
    // Error classification
    // ****************************************
    req_t req;
    logic partial;
    logic chk_on;
    logic [5:0] syn;
    logic par_bad;
    logic ce;
    logic ue;
    err_t err;
    logic sync;
    logic class_ok;
    logic kind_hw;
    logic [4:0] etype;
    logic disrupt;
    logic [STRAND_W-1:0] target;

    assign req = req_t'(ACC_REQ);
    assign partial = (req == REQ_STORE) && (ACC_BYTE_EN != `FULL_STORE);
    // Disabled arrays hide data and tag faults; not-data still flows
    assign chk_on = ACC_VALID && array_en && (req != REQ_STORE || partial);
    assign syn = ACC_CHECK[5:0] ^ hamming(ACC_DATA);
    assign par_bad = ^{ACC_DATA, ACC_CHECK};
    assign ce = (chk_on && par_bad) || (ACC_VALID && array_en && ACC_TAG_CE);
    assign ue = chk_on && !par_bad && (syn != 6'h0);
    assign sync = (req == REQ_ITLB) || (req == REQ_DTLB) || (req == REQ_IFETCH) ||
                  (req == REQ_LOAD);
    assign target = (req == REQ_WRITEBACK || req == REQ_DMA_RD) ? steer : ACC_STRAND;

    always_comb begin
        err = `ERR_NONE;
        if (ACC_VALID && ACC_NOT_DATA) begin
            err = `ERR_ND;
        end else if (ue) begin
            err = `ERR_UE;
        end else if (ce) begin
            err = `ERR_CE;
        end
    end

    always_comb begin
        class_ok = class_r[`CLASS_SOC];
        etype = `ET_SWCE;
        kind_hw = 1'b0;
        unique case (req)
            REQ_ITLB: begin
                class_ok = class_r[`CLASS_TW];
                etype = `ET_ITLB;
            end
            REQ_DTLB: begin
                class_ok = class_r[`CLASS_TW];
                etype = `ET_DTLB;
            end
            REQ_IFETCH: begin
                class_ok = class_r[`CLASS_IF];
                etype = `ET_IFETCH;
            end
            REQ_LOAD: begin
                class_ok = class_r[`CLASS_LD];
                etype = `ET_LOAD;
            end
            REQ_STORE, REQ_WRITEBACK: begin
                kind_hw = (err == `ERR_CE);
                etype = kind_hw ? `ET_HWCE : `ET_UE;
            end
            default: etype = (err == `ERR_CE) ? `ET_SWCE : `ET_UE;
        endcase
        if (err == `ERR_ND && !sync) begin
            etype = `ET_ND;
        end
    end

    // Sync UE and not-data go precise; everything else reported disrupts
    assign disrupt = (err != `ERR_NONE) && (!sync || err == `ERR_CE);

    // ****************************************
    // Packets, corrected data and capture
    // ****************************************
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            LR_VALID <= 1'b0;
            LR_ERR <= `ERR_NONE;
            LR_STRAND <= '0;
            LR_DATA <= 32'h0;
            EI_VALID <= 1'b0;
            EI_ERR <= `ERR_NONE;
            EI_STRAND <= '0;
            PRECISE_TRAP <= 1'b0;
            PRECISE_STRAND <= '0;
        end else begin
            LR_VALID <= ACC_VALID && sync;
            LR_STRAND <= ACC_STRAND;
            // Only the returned word is fixed; the array keeps the bad bit
            LR_DATA <= ACC_DATA ^ (ce && chk_on ? flip_of(syn) : 32'h0);
            LR_ERR <= (err == `ERR_CE && !report) ? `ERR_NONE : err;
            EI_VALID <= ACC_VALID && !sync && err != `ERR_NONE &&
                        (err != `ERR_CE || report);
            EI_ERR <= err;
            EI_STRAND <= target;
            PRECISE_TRAP <= sync && (err == `ERR_UE || err == `ERR_ND);
            PRECISE_STRAND <= ACC_STRAND;
        end
    end

    // Capture runs even with reporting off, so software can still look
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            esr_r <= 32'h0;
            addr_r <= '0;
        end else if (err == `ERR_CE) begin
            esr_r <= 32'h0;
            esr_r[`ESR_ACC] <= 1'b1;
            esr_r[`ESR_RW] <= (req != REQ_DTLB) && ACC_RW;
            esr_r[`ESR_MODE] <= (req != REQ_DTLB) && ACC_MODE;
            esr_r[`ESR_STRAND_LO +: STRAND_W] <= ACC_STRAND;
            esr_r[6:0] <= {par_bad, syn};
            addr_r <= ACC_PA;
        end
    end

    // ****************************************
    // Per-strand status and trap requests
    // ****************************************
    for (genvar i = 0; i < NUM_STRANDS; i++) begin : g_strand
        logic f_r;
        logic [4:0] et_r;
        logic psw_r;
        logic phw_r;
        logic sw_trap_r;
        logic hw_trap_r;
        logic hit;
        logic clr;
        logic open_win;
        logic take_sw;
        logic take_hw;

        assign hit = disrupt && report && class_ok &&
                     target == STRAND_W'(i);
        assign clr = do_write && awaddr_r == `OFF_DESR_HI && wstrb_r[3] &&
                     !wdata_r[`DESR_F] && sel_r == STRAND_W'(i);
        assign open_win = INTERRUPT_ENABLE[i] || !HYPERPRIVILEGE[i];
        assign take_sw = psw_r && trapen_r[`TRAPEN_SW] && open_win;
        assign take_hw = phw_r && trapen_r[`TRAPEN_HW] && open_win;

        // A new error beats a same-cycle software clear
        always_ff @(posedge CLK_SYS or negedge RESET_N) begin
            if (!RESET_N) begin
                f_r <= 1'b0;
                et_r <= 5'h0;
            end else if (hit) begin
                f_r <= 1'b1;
                if (!f_r) begin
                    et_r <= etype;
                end
            end else if (clr) begin
                f_r <= 1'b0;
            end
        end

        always_ff @(posedge CLK_SYS or negedge RESET_N) begin
            if (!RESET_N) begin
                psw_r <= 1'b0;
                phw_r <= 1'b0;
            end else begin
                if (hit && !kind_hw) begin
                    psw_r <= 1'b1;
                end else if (clr || take_sw) begin
                    psw_r <= 1'b0;
                end
                if (hit && kind_hw) begin
                    phw_r <= 1'b1;
                end else if (clr || take_hw) begin
                    phw_r <= 1'b0;
                end
            end
        end

        always_ff @(posedge CLK_SYS or negedge RESET_N) begin
            if (!RESET_N) begin
                sw_trap_r <= 1'b0;
                hw_trap_r <= 1'b0;
            end else begin
                sw_trap_r <= take_sw;
                hw_trap_r <= take_hw;
            end
        end

        assign f_v[i] = f_r;
        assign et_v[i] = et_r;
        assign psw_v[i] = psw_r;
        assign phw_v[i] = phw_r;
        assign SW_TRAP[i] = sw_trap_r;
        assign HW_TRAP[i] = hw_trap_r;
    end

endmodule : l2_correctable_error_report

// [l2ce_asserts.sv]
// Checker of the error reporter's packet and trap ports.
// Assumes one clock domain, CLK_SYS with RESET_N active low.
`timescale 1ns/1ns
module l2ce_asserts
    import l2ce_pkg::*;
#(
    parameter int NUM_STRANDS = 8,
    parameter int STRAND_W = 3
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic ACC_VALID,
    input wire logic [2:0] ACC_REQ,
    input wire logic [STRAND_W-1:0] ACC_STRAND,
    input wire logic ACC_NOT_DATA,
    input wire logic [NUM_STRANDS-1:0] INTERRUPT_ENABLE,
    input wire logic [NUM_STRANDS-1:0] HYPERPRIVILEGE,
    input wire logic LR_VALID,
    input wire logic [1:0] LR_ERR,
    input wire logic [STRAND_W-1:0] LR_STRAND,
    input wire logic EI_VALID,
    input wire logic [1:0] EI_ERR,
    input wire logic [STRAND_W-1:0] EI_STRAND,
    input wire logic PRECISE_TRAP,
    input wire logic [STRAND_W-1:0] PRECISE_STRAND,
    input wire logic [NUM_STRANDS-1:0] SW_TRAP,
    input wire logic [NUM_STRANDS-1:0] HW_TRAP
);
    // ****
    // Port relations
    // ****
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);
    sequence s_sync;
        ACC_VALID && ACC_REQ <= 3'h3;
    endsequence
    sequence s_async_nd;
        ACC_VALID && ACC_NOT_DATA && (ACC_REQ == 3'h4 || ACC_REQ == 3'h5);
    endsequence
    a_lr_follows: assert property (s_sync |=> LR_VALID && LR_STRAND == $past(ACC_STRAND))
        else $error("load return missing");
    a_lr_not_store: assert property (ACC_VALID && ACC_REQ >= 3'h5 |=> !LR_VALID)
        else $error("load return for async request");
    a_precise_nd: assert property (s_sync ##0 ACC_NOT_DATA |=> PRECISE_TRAP
        && LR_ERR == 2'h3)
        else $error("not-data load without precise trap");
    a_precise_src: assert property (PRECISE_TRAP |-> $past(ACC_VALID)
        && $past(ACC_REQ) <= 3'h3 && PRECISE_STRAND == $past(ACC_STRAND))
        else $error("precise trap without sync request");
    a_ei_async: assert property (EI_VALID |-> $past(ACC_VALID) && $past(ACC_REQ) >= 3'h4
        && EI_ERR != 2'h0)
        else $error("indication without async error");
    a_ei_requester: assert property (s_async_nd |=> EI_VALID && EI_ERR == 2'h3
        && EI_STRAND == $past(ACC_STRAND))
        else $error("indication not sent to requester");
    a_trap_once: assert property ((SW_TRAP | HW_TRAP) != '0
        |=> ((SW_TRAP & $past(SW_TRAP)) | (HW_TRAP & $past(HW_TRAP))) == '0)
        else $error("trap taken twice");
    a_trap_gate: assert property ((SW_TRAP | HW_TRAP) != '0 |-> ((SW_TRAP | HW_TRAP)
        & ~($past(INTERRUPT_ENABLE) | ~$past(HYPERPRIVILEGE))) == '0)
        else $error("trap taken while masked");
endmodule : l2ce_asserts
bind l2_correctable_error_report l2ce_asserts #(.NUM_STRANDS(NUM_STRANDS), .STRAND_W(STRAND_W))
    i_l2ce_asserts (.*);

// [core_strands.sv]
// Model of the requesting strands: privilege state and taken-trap counts.
// Assumes the reporter's clock and reset.
`timescale 1ns/1ns
module core_strands #(
    parameter int N = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [N-1:0] ie_want,
    input wire logic [N-1:0] hp_want,
    input wire logic [N-1:0] sw_trap,
    input wire logic [N-1:0] hw_trap,
    output logic [N-1:0] ie,
    output logic [N-1:0] hpriv,
    output int sw_taken,
    output int hw_taken
);
    // ****
    // Strand state
    // ****
    // Strands leave reset privileged and masked, so no trap can slip out early
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ie <= '0;
            hpriv <= '1;
        end else begin
            ie <= ie_want;
            hpriv <= hp_want;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sw_taken <= 0;
            hw_taken <= 0;
        end else begin
            sw_taken <= sw_taken + $countones(sw_trap);
            hw_taken <= hw_taken + $countones(hw_trap);
        end
    end
endmodule : core_strands

// [test_l2_correctable_error_report.sv]
// Self-checking bench of the cache error reporter.
// Assumes the reporter with 8 strands and the strand model.
`timescale 1ns/1ns
`include "l2ce_regs.svh"
module test_l2_correctable_error_report
    import l2ce_pkg::*;
;
    logic CLK_SYS, RESET_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
    logic ARVALID, ARREADY, RVALID, RREADY, ACC_VALID, ACC_RW, ACC_MODE;
    logic ACC_TAG_CE, ACC_NOT_DATA, LR_VALID, EI_VALID, PRECISE_TRAP;
    logic [11:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, ACC_DATA, LR_DATA, rd_d;
    logic [3:0] WSTRB, ACC_BYTE_EN;
    logic [1:0] BRESP, RRESP, LR_ERR, EI_ERR, rd_r;
    logic [2:0] ACC_REQ, ACC_STRAND, LR_STRAND, EI_STRAND, PRECISE_STRAND;
    logic [39:6] ACC_PA;
    logic [6:0] ACC_CHECK;
    logic [7:0] INTERRUPT_ENABLE, HYPERPRIVILEGE, SW_TRAP, HW_TRAP, ie_want, hp_want;
    int sw_taken, hw_taken, err_total, compares;
    l2_correctable_error_report i_l2_correctable_error_report (.*);
    core_strands i_core_strands (.clk(CLK_SYS), .rst_n(RESET_N), .ie_want(ie_want),
        .hp_want(hp_want), .sw_trap(SW_TRAP), .hw_trap(HW_TRAP), .ie(INTERRUPT_ENABLE),
        .hpriv(HYPERPRIVILEGE), .sw_taken(sw_taken), .hw_taken(hw_taken));
    initial begin
        CLK_SYS = 1'b0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end
    // ****
    // Shared tasks
    // ****
    task conclude;
        $display("Compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    task chk(input string w, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK_SYS);
        AWADDR <= a;
        AWVALID <= 1'b1;
        WDATA <= d;
        WSTRB <= 4'hf;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge CLK_SYS);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
            if (BVALID) break;
        end
        BREADY <= 1'b0;
        chk("write wait", 32'h0, {29'h0, n == 40, BRESP});
        if (n == 40) conclude();
    endtask : wr
    task rd(input logic [11:0] a);
        int n;
        @(posedge CLK_SYS);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge CLK_SYS);
            if (ARREADY) ARVALID <= 1'b0;
            if (RVALID) break;
        end
        rd_d = RDATA;
        rd_r = RRESP;
        RREADY <= 1'b0;
        chk("read wait", 32'h0, {31'h0, n == 40});
        if (n == 40) conclude();
    endtask : rd
    task rchk(input logic [11:0] a, input logic [31:0] e, input string w);
        rd(a);
        chk(w, e, rd_d);
    endtask : rchk
    // Data 1 with zero check bits is one flipped bit; data 3 is two
    task acc(input logic [2:0] q, input logic [2:0] s, input logic [31:0] d,
        input logic nd, input logic [3:0] be = 4'hf);
        @(posedge CLK_SYS);
        ACC_VALID <= 1'b1;
        ACC_REQ <= q;
        ACC_STRAND <= s;
        ACC_RW <= s[0];
        ACC_DATA <= d;
        ACC_NOT_DATA <= nd;
        ACC_BYTE_EN <= be;
        @(posedge CLK_SYS);
        ACC_VALID <= 1'b0;
        #1;
    endtask : acc
    task tchk(input logic [7:0] sw, input logic [7:0] hw);
        @(posedge CLK_SYS);
        #1;
        chk("sw trap", sw, SW_TRAP);
        chk("hw trap", hw, HW_TRAP);
    endtask : tchk
    // ****
    // Scenarios
    // ****
    task t_reset;
        rchk(`OFF_CTRL, `CTRL_RST, "ctrl");
        rchk(`OFF_DESR_HI, 32'h0, "status");
        rd(12'h0f0);
        chk("unmapped", 32'h3, rd_r);
        $display("reset test done");
    endtask : t_reset
    task t_load;
        wr(`OFF_CLASS, 32'hf);
        wr(`OFF_TRAPEN, 32'h3);
        wr(`OFF_SEL, 32'h5);
        acc(REQ_LOAD, 3'h5, 32'h1, 1'b0);
        chk("lr code", 32'h1, LR_ERR);
        chk("lr data", 32'h0, LR_DATA);
        chk("no precise", 32'h0, PRECISE_TRAP);
        tchk(8'h20, 8'h0);
        rchk(`OFF_DESR_HI, 32'h8400_0000, "load type");
        rchk(`OFF_ADDR_LO, 32'h1234_5678, "address");
        wr(`OFF_DESR_HI, 32'h0);
        acc(REQ_IFETCH, 3'h2, 32'h3, 1'b0);
        chk("ue code", 32'h2, LR_ERR);
        chk("ue strand", 32'h2, PRECISE_STRAND);
        acc(REQ_ITLB, 3'h1, 32'h0, 1'b1);
        chk("nd trap", 32'h1, PRECISE_TRAP);
        tchk(8'h0, 8'h0);
        $display("load test done");
    endtask : t_load
    task t_pending;
        int n;
        ie_want <= 8'h0;
        wr(`OFF_TRAPEN, 32'h0);
        wr(`OFF_SEL, 32'h1);
        acc(REQ_DTLB, 3'h1, 32'h1, 1'b0);
        tchk(8'h0, 8'h0);
        rchk(`OFF_DESR_LO, 32'h1, "pending");
        rchk(`OFF_DESR_HI, 32'h8300_0000, "walk type");
        rchk(`OFF_ESR, 32'h8001_0043, "walk status");
        wr(`OFF_TRAPEN, 32'h1);
        rchk(`OFF_DESR_LO, 32'h1, "held");
        wr(`OFF_DESR_HI, 32'h0);
        rchk(`OFF_DESR_LO, 32'h0, "discarded");
        acc(REQ_DTLB, 3'h1, 32'h1, 1'b0);
        n = sw_taken;
        @(posedge CLK_SYS);
        hp_want <= 8'h0;
        repeat (4) @(posedge CLK_SYS);
        chk("taken", n + 1, sw_taken);
        rchk(`OFF_DESR_LO, 32'h0, "cleared");
        ie_want <= 8'hff;
        $display("pending test done");
    endtask : t_pending
    task t_async;
        wr(`OFF_CTRL, 32'h63);
        wr(`OFF_TRAPEN, 32'h3);
        acc(REQ_STORE, 3'h3, 32'h1, 1'b0, 4'h3);
        chk("ei code", 32'h1, EI_ERR);
        chk("ei target", 32'h3, EI_STRAND);
        tchk(8'h0, 8'h08);
        acc(REQ_WRITEBACK, 3'h3, 32'h1, 1'b0);
        chk("steered", 32'h6, EI_STRAND);
        tchk(8'h0, 8'h40);
        acc(REQ_DMA_RD, 3'h2, 32'h1, 1'b0);
        tchk(8'h40, 8'h0);
        acc(REQ_PREFETCH, 3'h4, 32'h0, 1'b1);
        chk("nd target", 32'h4, EI_STRAND);
        tchk(8'h10, 8'h0);
        wr(`OFF_SEL, 32'h3);
        rchk(`OFF_DESR_HI, 32'h8900_0000, "hw type");
        $display("async test done");
    endtask : t_async
    task t_quiet;
        wr(`OFF_CTRL, 32'h2);
        wr(`OFF_SEL, 32'h0);
        acc(REQ_LOAD, 3'h0, 32'h1, 1'b0);
        chk("silent code", 32'h0, LR_ERR);
        tchk(8'h0, 8'h0);
        wr(`OFF_CTRL, 32'h3);
        wr(`OFF_CLASS, 32'h0);
        acc(REQ_LOAD, 3'h0, 32'h1, 1'b0);
        chk("class off code", 32'h1, LR_ERR);
        tchk(8'h0, 8'h0);
        rchk(`OFF_DESR_HI, 32'h0, "untouched");
        $display("quiet test done");
    endtask : t_quiet
    initial begin
        {RESET_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, ACC_VALID} = '0;
        {AWADDR, ARADDR, WDATA, WSTRB, ACC_DATA, ACC_BYTE_EN, ACC_REQ, ACC_STRAND} = '0;
        {ACC_RW, ACC_MODE, ACC_TAG_CE, ACC_NOT_DATA, ACC_CHECK} = '0;
        ACC_PA = 34'h1_1234_5678;
        ie_want = 8'hff;
        hp_want = 8'hff;
        err_total = 0;
        compares = 0;
        repeat (12) @(posedge CLK_SYS);
        RESET_N <= 1'b1;
        t_reset();
        t_load();
        t_pending();
        t_async();
        t_quiet();
        conclude();
    end
endmodule : test_l2_correctable_error_report
